// >>> audio_port_pkg.sv
// Constants, field layout and codes for the serial audio output port
package audio_port_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CTRL_W = 10;
	localparam int SAMPLE_W = 24;
	localparam int SAMPLE_MSB = SAMPLE_W - 1;
	localparam int SYNC_STAGES = 3;
	localparam int COUNT_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

	// Reset: I2S, 16-bit words, rising capture, analog only, reference clock
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h004;

	localparam int FMT_LSB = 0;
	localparam int WL_LSB = 2;
	localparam int DSP_SECOND_BIT = 4;
	localparam int FALL_BIT = 5;
	localparam int MODE_LSB = 6;
	localparam int XTAL_BIT = 8;
	localparam int GENERAL_OUTPUT_THREE_BIT = 9;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_COUNT_LSB = 8;

	typedef enum logic [1:0] {FMT_I2S = 2'h0, FMT_LJ = 2'h1, FMT_DSP = 2'h2} fmt_t;
	typedef enum logic [1:0] {OUT_ANALOG = 2'h0, OUT_DIGITAL = 2'h1, OUT_BOTH = 2'h2} mode_t;

	localparam logic [1:0] WL_CODE_8 = 2'h0;
	localparam logic [1:0] WL_CODE_16 = 2'h1;
	localparam logic [1:0] WL_CODE_20 = 2'h2;
	localparam logic [4:0] WL_8 = 5'h08;
	localparam logic [4:0] WL_16 = 5'h10;
	localparam logic [4:0] WL_20 = 5'h14;
	localparam logic [4:0] WL_24 = 5'h18;

	function automatic logic [4:0] word_bits(input logic [1:0] code);
		case (code)
			WL_CODE_8: word_bits = WL_8;
			WL_CODE_16: word_bits = WL_16;
			WL_CODE_20: word_bits = WL_20;
			default: word_bits = WL_24;
		endcase
	endfunction : word_bits
endpackage : audio_port_pkg

// >>> audio_serial_out.sv
// Slave serial audio output port with register port and bit-clock domain
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
module audio_serial_out (
	// System clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire logic [audio_port_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [audio_port_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [audio_port_pkg::DATA_W-1:0] reg_rdata,
	// Sample source, samples left-aligned in 24 bits
	input wire logic [audio_port_pkg::SAMPLE_W-1:0] sample_left,
	input wire logic [audio_port_pkg::SAMPLE_W-1:0] sample_right,
	input wire logic sample_valid,
	output logic sample_ready,
	// Serial link
	input wire logic audio_bit_clock,
	input wire logic audio_frame_sync,
	output logic serial_data,
	output logic serial_data_oe,
	// Shared pins and modes
	output logic general_output_three,
	output logic general_output_three_oe,
	output logic analog_enable,
	output logic crystal_mode
);
	import audio_port_pkg::*;

	logic [1:0] rst_pipe;
	logic rst_n_sys;
	logic [CTRL_W-1:0] ctrl;
	logic [SAMPLE_W-1:0] hold_left;
	logic [SAMPLE_W-1:0] hold_right;
	logic [CTRL_W-1:0] hold_ctrl;
	logic req_tog;
	logic ack_tog;
	logic [SYNC_STAGES-1:0] ack_sync;
	logic [COUNT_W-1:0] hs_count;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n_sys = rst_pipe[1];

	// Register decode
	wire wr_ctrl = reg_write && (reg_addr == ADDR_CTRL);
	wire sel_ctrl = reg_addr == ADDR_CTRL;
	wire sel_status = reg_addr == ADDR_STATUS;
	wire ack_stable = ack_sync[1] == ack_sync[2];
	wire busy = !ack_stable || (ack_sync[2] != req_tog);
	wire [DATA_W-1:0] status_word = {hs_count, 7'h00, busy};
	wire [DATA_W-1:0] ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
	wire [DATA_W-1:0] read_word = sel_ctrl ? ctrl_word : (sel_status ? status_word : 16'h0000);
	wire take = sample_valid && sample_ready;
	wire mode_t mode = mode_t'(ctrl[MODE_LSB +: 2]);

	always_ff @(posedge clock or negedge rst_n_sys)
	begin
		if (!rst_n_sys)
			ctrl <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= reg_wdata[CTRL_W-1:0];
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n_sys)
	begin
		if (!rst_n_sys)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_read ? read_word : 16'h0000;
	end

	// Toggle handshake; the holding registers stay still until the link acknowledges
	assign sample_ready = !busy;

	always_ff @(posedge clock or negedge rst_n_sys)
	begin
		if (!rst_n_sys)
		begin
			hold_left <= 24'h000000;
			hold_right <= 24'h000000;
			hold_ctrl <= CTRL_RESET;
			req_tog <= 1'b0;
			hs_count <= 8'h00;
		end
		else if (take)
		begin
			hold_left <= sample_left;
			hold_right <= sample_right;
			hold_ctrl <= ctrl;
			req_tog <= !req_tog;
			hs_count <= hs_count + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n_sys)
	begin
		if (!rst_n_sys)
			ack_sync <= 3'h0;
		else
			ack_sync <= {ack_sync[1:0], ack_tog};
	end

	// Pin roles
	assign serial_data_oe = mode != OUT_ANALOG;
	assign general_output_three_oe = mode == OUT_ANALOG;
	assign general_output_three = ctrl[GENERAL_OUTPUT_THREE_BIT];
	assign analog_enable = mode != OUT_DIGITAL;
	assign crystal_mode = ctrl[XTAL_BIT];

	// Link domain, clocked by the master's bit clock
	logic [1:0] lrst_pipe;
	logic lrst_n;
	logic [SYNC_STAGES-1:0] req_sync;
	logic [SAMPLE_W-1:0] link_left;
	logic [SAMPLE_W-1:0] link_right;
	logic [CTRL_W-1:0] lcfg;
	logic fs_q;
	logic chan_left;
	logic pend_right;
	logic rb;
	logic fall_bit;
	logic [SAMPLE_W-1:0] sh;
	logic [4:0] cnt;

	// Bit clock may stop outside frames; reset still asserts without it
	always_ff @(posedge audio_bit_clock or negedge rst_n_sys)
	begin
		if (!rst_n_sys)
			lrst_pipe <= 2'h0;
		else
			lrst_pipe <= {lrst_pipe[0], 1'b1};
	end
	assign lrst_n = lrst_pipe[1];

	wire req_new = (req_sync[1] == req_sync[2]) && (req_sync[2] != ack_tog);

	always_ff @(posedge audio_bit_clock or negedge lrst_n)
	begin
		if (!lrst_n)
			req_sync <= 3'h0;
		else
			req_sync <= {req_sync[1:0], req_tog};
	end

	always_ff @(posedge audio_bit_clock or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			link_left <= 24'h000000;
			link_right <= 24'h000000;
			lcfg <= CTRL_RESET;
			ack_tog <= 1'b0;
		end
		else if (req_new)
		begin
			link_left <= hold_left;
			link_right <= hold_right;
			lcfg <= hold_ctrl;
			ack_tog <= req_sync[2];
		end
	end

	// Frame sync is launched by the master on this clock, so it needs no synchroniser
	wire fmt_t fmt = fmt_t'(lcfg[FMT_LSB +: 2]);
	wire dsp = fmt == FMT_DSP;
	wire [4:0] width = word_bits(lcfg[WL_LSB +: 2]);
	wire second = dsp ? lcfg[DSP_SECOND_BIT] : (fmt == FMT_I2S);
	wire fs_rise = audio_frame_sync && !fs_q;
	wire start = dsp ? fs_rise : (audio_frame_sync != fs_q);
	wire start_left = dsp || ((fmt == FMT_I2S) ? !audio_frame_sync : audio_frame_sync);
	wire [SAMPLE_W-1:0] start_word = start_left ? link_left : link_right;
	wire [SAMPLE_W-1:0] next_word = chan_left ? link_right : link_left;
	wire start_msb = start_word[SAMPLE_MSB];
	wire start_next = start_word[SAMPLE_MSB-1];
	wire sh_msb = sh[SAMPLE_MSB];
	wire [SAMPLE_W-1:0] load_sh = second ? (start_word << 1) : (start_word << 2);
	wire [4:0] load_cnt = second ? (width - 5'h01) : (width - 5'h02);
	wire load_rb = second ? start_msb : start_next;

	// rb holds the bit the master captures at the next capture edge
	always_ff @(posedge audio_bit_clock or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			fs_q <= 1'b0;
			chan_left <= 1'b0;
			pend_right <= 1'b0;
			rb <= 1'b0;
			sh <= 24'h000000;
			cnt <= 5'h00;
		end
		else
		begin
			fs_q <= audio_frame_sync;
			if (start)
			begin
				chan_left <= start_left;
				pend_right <= dsp;
				rb <= load_rb;
				sh <= load_sh;
				cnt <= load_cnt;
			end
			else if (cnt != 5'h00)
			begin
				rb <= sh_msb;
				sh <= sh << 1;
				cnt <= cnt - 5'h01;
			end
			else if (pend_right)
			begin
				chan_left <= 1'b0;
				pend_right <= 1'b0;
				rb <= link_right[SAMPLE_MSB];
				sh <= link_right << 1;
				cnt <= width - 5'h01;
			end
			else
				rb <= next_word[SAMPLE_MSB];
		end
	end

	// Rising capture: launch half a cycle later on the falling edge
	always_ff @(negedge audio_bit_clock or negedge lrst_n)
	begin
		if (!lrst_n)
			fall_bit <= 1'b0;
		else
			fall_bit <= rb;
	end

	// Falling capture: launch straight from the rising-edge register
	assign serial_data = lcfg[FALL_BIT] ? rb : fall_bit;

	AST_PINS_ANALOG: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(mode == OUT_ANALOG) |-> (general_output_three_oe && !serial_data_oe && analog_enable))
		else $error("pin roles wrong in analog mode");

	AST_I2S_MSB: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(fmt == FMT_I2S && start) |=> (rb == $past(start_msb)) && (cnt == $past(width) - 5'h01))
		else $error("I2S MSB not presented for second edge");

	AST_I2S_CHAN: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(fmt == FMT_I2S && start) |=> (chan_left == !$past(audio_frame_sync)))
		else $error("I2S channel does not follow sync level");

	AST_LJ_MSB: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(fmt == FMT_LJ && start) |=> (rb == $past(start_next)) && (cnt == $past(width) - 5'h02))
		else $error("left-justified MSB not on first edge");

	AST_LJ_CHAN: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(fmt == FMT_LJ && start) |=> (chan_left == $past(audio_frame_sync)))
		else $error("left-justified channel does not follow sync level");

	AST_SHIFT: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && cnt != 5'h00) |=> (rb == $past(sh_msb)) && (cnt == $past(cnt) - 5'h01))
		else $error("word bits not shifted in descending order");

	AST_DSP_B2B: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && cnt == 5'h00 && pend_right) |=> (!pend_right && !chan_left
		&& cnt == $past(width) - 5'h01))
		else $error("DSP right word did not follow left at once");

	AST_DSP_EDGE: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(dsp && start) |=> chan_left && pend_right
		&& (cnt == ($past(second) ? $past(width) - 5'h01 : $past(width) - 5'h02)))
		else $error("DSP left word not started on selected edge");

	AST_WIDTH: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(width == WL_8 || width == WL_16 || width == WL_20 || width == WL_24) && (cnt < width))
		else $error("word length outside supported set");

	AST_PINS_DIGITAL: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(mode == OUT_DIGITAL) |-> (serial_data_oe && !general_output_three_oe && !analog_enable))
		else $error("pin roles wrong in digital mode");

	AST_PINS_BOTH: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(mode == OUT_BOTH) |-> (serial_data_oe && !general_output_three_oe && analog_enable))
		else $error("pin roles wrong in concurrent mode");

	AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (!rst_n_sys)
		wr_ctrl |=> (ctrl == $past(reg_wdata[CTRL_W-1:0])))
		else $error("control write not taken");

	AST_CTRL_HOLD: assert property (@(posedge clock) disable iff (!rst_n_sys)
		!wr_ctrl |=> $stable(ctrl))
		else $error("control changed without a write");

	AST_RDATA_ZERO: assert property (@(posedge clock) disable iff (!rst_n_sys)
		!reg_read |=> (reg_rdata == 16'h0000))
		else $error("read data not zero outside a read");

	AST_RDATA_CTRL: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(reg_read && sel_ctrl) |=> (reg_rdata == $past(ctrl_word)))
		else $error("control read returned wrong word");

	AST_RDATA_STATUS: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(reg_read && sel_status) |=> (reg_rdata == $past(status_word)))
		else $error("status read returned wrong word");

	AST_RDATA_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n_sys)
		(reg_read && !sel_ctrl && !sel_status) |=> (reg_rdata == 16'h0000))
		else $error("unmapped read not zero");

	AST_TAKE_BUSY: assert property (@(posedge clock) disable iff (!rst_n_sys)
		take |=> !sample_ready)
		else $error("ready stayed high after a take");

	AST_HOLD_STILL: assert property (@(posedge clock) disable iff (!rst_n_sys)
		!take |=> ($stable(hold_left) && $stable(hold_right) && $stable(hold_ctrl)))
		else $error("holding registers moved without a take");

	AST_COUNT: assert property (@(posedge clock) disable iff (!rst_n_sys)
		take |=> (hs_count == $past(hs_count) + 8'h01))
		else $error("accepted pair count not advanced");

	AST_LOAD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		req_new |=> (link_left == $past(hold_left)) && (lcfg == $past(hold_ctrl)))
		else $error("link did not load the offered pair");

	AST_ACK: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		req_new |=> (ack_tog != $past(ack_tog)))
		else $error("link did not acknowledge a load");

	AST_LINK_HOLD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		!req_new |=> ($stable(link_left) && $stable(link_right) && $stable(lcfg)))
		else $error("link words moved without a load");

	AST_DATA_RISE: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		!lcfg[FALL_BIT] |-> (serial_data == rb))
		else $error("data not settled at rising capture");

	AST_DATA_FALL: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		lcfg[FALL_BIT] |-> (serial_data == rb))
		else $error("data not launched from rising register");

	AST_IDLE_PRELOAD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && cnt == 5'h00 && !pend_right) |=> (rb == $past(next_word[SAMPLE_MSB])))
		else $error("idle clocks do not present next MSB");

	AST_SHIFT_WORD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && cnt != 5'h00) |=> (sh == ($past(sh) << 1)))
		else $error("shift register did not move down one bit");

	AST_PEND_CLEAR: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(start && !dsp) |=> !pend_right)
		else $error("pending right word outside DSP format");

	AST_FS_TRACK: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		1'b1 |=> (fs_q == $past(audio_frame_sync)))
		else $error("frame sync history lost");

	AST_DSP_FIRST: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(dsp && start && !second) |=> (rb == $past(start_next)))
		else $error("DSP first-edge option misplaced MSB");

	AST_DSP_SECOND: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(dsp && start && second) |=> (rb == $past(start_msb)))
		else $error("DSP second-edge option misplaced MSB");

	AST_RIGHT_LOAD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && cnt == 5'h00 && pend_right) |=> (rb == $past(link_right[SAMPLE_MSB])))
		else $error("DSP right MSB not presented at once");

	AST_CHAN_HOLD: assert property (@(posedge audio_bit_clock) disable iff (!lrst_n)
		(!start && !(cnt == 5'h00 && pend_right)) |=> $stable(chan_left))
		else $error("channel changed without a frame sync");
endmodule : audio_serial_out

// >>> audio_master_model.sv
// Behavioural serial audio master: makes bit clock and frame sync, captures data
`timescale 1ns/10ps
module audio_master_model (
	// Link pins
	output logic audio_bit_clock,
	output logic audio_frame_sync,
	input wire logic serial_data
);
	import audio_port_pkg::*;
	logic fall_val;
	initial
	begin
		audio_bit_clock = 1'b0;
		audio_frame_sync = 1'b0;
		fall_val = 1'b0;
	end
	always @(negedge audio_bit_clock)
		fall_val <= serial_data;
	// Clock stands still outside frames: 16 lead-in clocks, then two 32-clock slots.
	// Sync keeps its old level until the new setup has reached the link.
	task automatic run_frame(input logic [1:0] fmt, input int n, input int lead,
		input logic fall, output logic [23:0] left, output logic [23:0] right);
		int k;
		int right_at;
		logic b;
		left = 24'h000000;
		right = 24'h000000;
		right_at = (fmt == FMT_DSP) ? lead + n : 32 + lead;
		for (k = -15; k <= 64; k++)
		begin
			if (k < 1)
			begin
				if (k >= -7)
					audio_frame_sync = (fmt == FMT_I2S);
			end
			else if (fmt == FMT_DSP)
				audio_frame_sync = (k == 1);
			else
				audio_frame_sync = (k <= 32) ^ (fmt == FMT_I2S);
			#16;
			audio_bit_clock = 1'b1;
			b = fall ? fall_val : serial_data;
			if (k >= lead && k < lead + n)
				left[23 - (k - lead)] = b;
			if (k >= right_at && k < right_at + n)
				right[23 - (k - right_at)] = b;
			#16;
			audio_bit_clock = 1'b0;
		end
	endtask : run_frame
endmodule : audio_master_model

// >>> tb.sv
// Self-checking bench for the serial audio output port
`timescale 1ns/10ps
module tb;
	import audio_port_pkg::*;
	logic clock;
	logic rstn;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [DATA_W-1:0] reg_rdata;
	logic [SAMPLE_W-1:0] sample_left;
	logic [SAMPLE_W-1:0] sample_right;
	logic sample_valid;
	logic sample_ready;
	logic audio_bit_clock;
	logic audio_frame_sync;
	logic serial_data;
	logic serial_data_oe;
	logic general_output_three;
	logic general_output_three_oe;
	logic analog_enable;
	logic crystal_mode;
	int num_errors;
	int compares;
	int cycles;
	logic [7:0] pairs;
	audio_serial_out dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .sample_left(sample_left), .sample_right(sample_right),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.audio_bit_clock(audio_bit_clock), .audio_frame_sync(audio_frame_sync),
		.serial_data(serial_data), .serial_data_oe(serial_data_oe),
		.general_output_three(general_output_three),
		.general_output_three_oe(general_output_three_oe),
		.analog_enable(analog_enable), .crystal_mode(crystal_mode));
	audio_master_model partner (.audio_bit_clock(audio_bit_clock),
		.audio_frame_sync(audio_frame_sync), .serial_data(serial_data));
	always #20 clock = ~clock;
	// A stuck handshake would otherwise hang the run
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors = num_errors + 1;
			final_report();
		end
	end
	task automatic final_report();
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic check_value(input string name, input logic [23:0] exp, input logic [23:0] got);
		compares = compares + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check_value
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		check_value("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
		@(posedge clock);
	endtask : reg_rd
	task automatic mode_case(input logic [1:0] m);
		logic [15:0] v;
		v = {6'h00, m[0], ~m[0], m, 6'h04};
		reg_wr(ADDR_CTRL, v);
		check_value("data_oe", {23'h0, m != 2'h0}, {23'h0, serial_data_oe});
		check_value("general_output_three_oe", {23'h0, m == 2'h0}, {23'h0, general_output_three_oe});
		check_value("analog", {23'h0, m != 2'h1}, {23'h0, analog_enable});
		check_value("crystal", {23'h0, ~m[0]}, {23'h0, crystal_mode});
		check_value("general_output_three", {23'h0, m[0]}, {23'h0, general_output_three});
		reg_wr(4'h8, 16'hFFFF);
		reg_rd(4'h8, 16'h0000);
		reg_rd(ADDR_CTRL, v);
	endtask : mode_case
	task automatic frame_case(input logic [1:0] fmt, input logic [1:0] wl);
		int n;
		int lead;
		logic [23:0] l;
		logic [23:0] r;
		logic [23:0] mask;
		logic [23:0] got_l;
		logic [23:0] got_r;
		n = (wl == 2'h3) ? 24 : (wl == 2'h2) ? 20 : 8 * (wl + 1);
		lead = (fmt == FMT_LJ || (fmt == FMT_DSP && !wl[0])) ? 1 : 2;
		mask = 24'hFFFFFF << (24 - n);
		l = 24'hC35A96 ^ {fmt, wl, 20'h0};
		r = 24'h3CA569 ^ {20'h0, wl, fmt};
		reg_wr(ADDR_CTRL, {8'h00, 2'h1, wl == 2'h2, wl[0], wl, fmt});
		sample_left <= l;
		sample_right <= r;
		sample_valid <= 1'b1;
		@(posedge clock);
		while (sample_ready !== 1'b1)
			@(posedge clock);
		sample_valid <= 1'b0;
		pairs = pairs + 8'h01;
		partner.run_frame(fmt, n, lead, wl == 2'h2, got_l, got_r);
		@(posedge clock);
		check_value("left", l & mask, got_l);
		check_value("right", r & mask, got_r);
		reg_rd(ADDR_STATUS, {pairs, 8'h00});
	endtask : frame_case
	initial
	begin
		clock = 1'b0;
		rstn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		sample_left = 24'h000000;
		sample_right = 24'h000000;
		sample_valid = 1'b0;
		num_errors = 0;
		compares = 0;
		cycles = 0;
		pairs = 8'h00;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		check_value("general_output_three_oe", 24'h000001, {23'h0, general_output_three_oe});
		reg_rd(ADDR_CTRL, {6'h00, CTRL_RESET});
		reg_rd(ADDR_STATUS, 16'h0000);
		for (int m = 0; m < 3; m++)
			mode_case(m[1:0]);
		for (int f = 0; f < 3; f++)
			for (int w = 0; w < 4; w++)
				frame_case(f[1:0], w[1:0]);
		final_report();
	end
endmodule : tb
